// ### design/fpsc_bitstore.sv
// per-block protect and lock bits with registered read
`timescale 1ns/1ns
module fpsc_bitstore
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clr_protect,
   input wire logic clr_lock,
   input wire logic [fpsc_pkg::BLK_W-1:0] wr_block,
   input wire logic [fpsc_pkg::BLK_W-1:0] rd_block,
   output logic rd_protect,
   output logic rd_lock
);
   import fpsc_pkg::*;
   // bits only ever fall to 0; erase of the flash cell is outside this slice
   typedef struct packed {
      logic [NUM_BLOCKS-1:0] protect;
      logic [NUM_BLOCKS-1:0] lock;
      logic rp;
      logic rl;
   } fpsc_bits_s;
   fpsc_bits_s st;
   fpsc_bits_s next_st;
   ////////////////////////////////////////////////////////////////////////////////
   // clear on program, read out through a register
   always_comb
   begin
      next_st = st;
      if (clr_protect)
      begin
         next_st.protect[wr_block] = 1'b0;
      end
      if (clr_lock)
      begin
         next_st.lock[wr_block] = 1'b0;
      end
      next_st.rp = st.protect[rd_block];
      next_st.rl = st.lock[rd_block];
   end
   // state register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st <= {{(2 * NUM_BLOCKS + 2){BIT_RESET}}};
      end
      else
      begin
         st <= next_st;
      end
   end
   assign rd_protect = st.rp;
   assign rd_lock = st.rl;
endmodule // fpsc_bitstore

// ### design/fpsc_pkg.sv
// shared constants, register map and state types of the flash protect/status slice
package fpsc_pkg;
   ////////////////////////////////////////////////////////////////////////////////
   // clock and timing
   localparam int CLK_PERIOD_NS = 4; // pclk period, 250 MHz
   localparam int OP_TIME_NS = 2000; // modelled program/erase/bit-program time
   localparam int OP_CYC = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_TIME_NS = 100; // handshake busy after each serial byte
   localparam int HOLD_CYC = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACCEPT_CYC = 2; // cycles the command-accept flag stays high
   ////////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] OFS_CMD = 8'h00; // write: command to command address
   localparam logic [7:0] OFS_TADDR = 8'h04; // target flash address
   localparam logic [7:0] OFS_TDATA = 8'h08; // write: data to target address
   localparam logic [7:0] OFS_RDATA = 8'h0C; // read: flash read at target address
   localparam logic [7:0] OFS_MODE0 = 8'h10; // flash_mode_reg0
   localparam logic [7:0] OFS_STAT0 = 8'h14; // flash_status_reg0
   localparam logic [7:0] OFS_IRQ_ST = 8'h18; // sticky events, write one to clear
   localparam logic [7:0] OFS_IRQ_MASK = 8'h1C; // interrupt enables
   ////////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int MODE0_ACCEPT = 0; // command_accept_flag, read only
   localparam int MODE0_EW1 = 1; // erase_write_mode1 select
   localparam int MODE0_VAR2 = 2; // serial variant 2 (uart) select
   localparam int STAT_READY = 7; // sequencer ready
   localparam int STAT_ERASE = 5; // erase_fault_flag / erase_status_bit
   localparam int STAT_PROG = 4; // write_fault_flag / program_status_bit
   localparam int PROT_STAT = 6; // protect bit status in protect read mode
   localparam int IRQ_DONE = 0; // operation finished
   localparam int IRQ_ERR = 1; // error flagged
   ////////////////////////////////////////////////////////////////////////////////
   // commands
   localparam logic [15:0] CMD_READ_ARRAY = 16'h00FF; // also the cancel value
   localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
   localparam logic [15:0] CMD_CLEAR = 16'h0050;
   localparam logic [15:0] CMD_PROGRAM = 16'h0043;
   localparam logic [15:0] CMD_ERASE = 16'h0020;
   localparam logic [15:0] CMD_LOCK = 16'h0077;
   localparam logic [15:0] CMD_PROTECT = 16'h0067;
   localparam logic [15:0] CMD_PROT_MODE = 16'h0061;
   localparam logic [15:0] CMD_CONFIRM = 16'h00D0;
   ////////////////////////////////////////////////////////////////////////////////
   // flash geometry
   localparam int ADDR_W = 20; // target address width
   localparam int BLK_W = 3; // block index width
   localparam int BLK_LSB = 16; // block index position in the address
   localparam int NUM_BLOCKS = 8;
   localparam int TIMER_W = 16;
   localparam logic BIT_RESET = 1'b1; // protect/lock bits: 1 = unprotected/unlocked
   ////////////////////////////////////////////////////////////////////////////////
   // state types
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT2, SEQ_BUSY} fpsc_seq_e;
   typedef enum logic [1:0] {OP_PROG, OP_ERASE, OP_LOCK, OP_PROT} fpsc_op_e;
   typedef enum logic [1:0] {RM_ARRAY, RM_STATUS, RM_PROT} fpsc_rmode_e;
endpackage

// ### design/fpsc_sync3.sv
// three-flop synchroniser with agreement filter for one pin
`timescale 1ns/1ns
module fpsc_sync3
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic level
);
   import fpsc_pkg::*;
   // s1 is read only by s2
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic val;
   } fpsc_sync_s;
   fpsc_sync_s st;
   fpsc_sync_s next_st;
   ////////////////////////////////////////////////////////////////////////////////
   // shift and accept a change once stages two and three agree
   always_comb
   begin
      next_st = st;
      next_st.s1 = pin;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      if (st.s2 == st.s3)
      begin
         next_st.val = st.s3;
      end
   end
   // state register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end
   assign level = st.val;
endmodule // fpsc_sync3

// ### design/fpsc_top.sv
// flash command sequencer: protect bit program, protect status mode, error status, serial pins
//
// Contract
// R1: 0067h then 00D0h starts protect program
// R2: software checks accept flag low between writes
// R3: successful protect program clears block bit
// R4: ready flag low during operation
// R5: 0061h enters protect bit status mode
// R6: any read returns addressed block protect status
// R7: software issues 0061h from RAM
// R8: fault flags mirror status bits, zero means fine
// R9: bad confirm data sets both flags
// R10: unavailable address sets both flags
// R11: locked or failed erase flags erase fault
// R12: locked, failed program or bit flags write fault
// R13: software clears status before handling errors
// R14: two serial variants on first uart channel
// R15: programmer holds serial clock low in reset
// R16: busy pin handshake or program monitor
// R17: 0050h clears status bits and fault flags
// R18: after operation return to mode-dependent read
// R19: protect status mode persists until next command
`timescale 1ns/1ns
module fpsc_top
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] array_rdata,
   input wire logic array_fail,
   input wire logic serial_clk_pin,
   input wire logic boot_select_pin,
   input wire logic ce_pin,
   input wire logic programming_mode_pin,
   output logic busy_pin,
   output logic serial_mode_active,
   output logic irq
);
   import fpsc_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      fpsc_seq_e seq; // sequencer state
      fpsc_op_e op; // pending or running operation
      fpsc_rmode_e rmode; // what a flash read returns
      logic [ADDR_W-1:0] taddr; // target address
      logic [TIMER_W-1:0] timer; // operation countdown
      logic [1:0] accept_cnt; // command_accept_flag while nonzero
      logic sr_erase; // erase_status_bit
      logic sr_prog; // program_status_bit
      logic ew1; // erase_write_mode1 selected
      logic variant2; // serial variant 2 selected
      logic [1:0] irq_st; // sticky events
      logic [1:0] irq_mask; // event enables
      logic [31:0] rdata; // read data captured in setup
      logic slverr; // error captured in setup
      logic link_prev; // last synchronised serial clock
      logic [2:0] bit_cnt; // serial clock edges in current byte
      logic [TIMER_W-1:0] hold; // byte handshake busy countdown
   } fpsc_top_s;
   fpsc_top_s st;
   fpsc_top_s next_st;
   ////////////////////////////////////////////////////////////////////////////////
   // helpers
   logic setup; // apb setup phase
   logic wr_acc; // apb write taking effect
   logic sclk; // synchronised serial clock
   logic boot_hi; // synchronised boot select
   logic ce_hi; // synchronised chip enable
   logic epm_hi; // synchronised programming mode pin
   logic blk_prot; // protect bit of the target block
   logic blk_lock; // lock bit of the target block
   logic clr_protect; // bitstore protect clear strobe
   logic clr_lock; // bitstore lock clear strobe
   logic [15:0] stat_word; // status register image
   logic [15:0] wdat; // low half of write data
   logic addr_bad; // target outside flash
   logic op_done; // last busy cycle
   logic fault; // failure at end of operation
   assign setup = psel & ~penable;
   assign wr_acc = psel & penable & pwrite;
   assign wdat = pwdata[15:0];
   assign addr_bad = st.taddr[ADDR_W-1]; // top half of the space is unpopulated
   assign op_done = (st.seq == SEQ_BUSY) && (st.timer == TIMER_W'(1));
   ////////////////////////////////////////////////////////////////////////////////
   // status word: ready, erase and program status
   always_comb
   begin
      stat_word = '0;
      stat_word[STAT_READY] = (st.seq != SEQ_BUSY); // [R4]
      stat_word[STAT_ERASE] = st.sr_erase; // [R8]
      stat_word[STAT_PROG] = st.sr_prog; // [R8]
   end
   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   fpsc_sync3 u_sync_sclk
   (
      .clk(pclk),
      .rst_n(presetn),
      .pin(serial_clk_pin),
      .level(sclk)
   );
   fpsc_sync3 u_sync_boot
   (
      .clk(pclk),
      .rst_n(presetn),
      .pin(boot_select_pin),
      .level(boot_hi)
   );
   fpsc_sync3 u_sync_ce
   (
      .clk(pclk),
      .rst_n(presetn),
      .pin(ce_pin),
      .level(ce_hi)
   );
   fpsc_sync3 u_sync_epm
   (
      .clk(pclk),
      .rst_n(presetn),
      .pin(programming_mode_pin),
      .level(epm_hi)
   );
   ////////////////////////////////////////////////////////////////////////////////
   // protect and lock bits
   fpsc_bitstore u_bits
   (
      .clk(pclk),
      .rst_n(presetn),
      .clr_protect(clr_protect),
      .clr_lock(clr_lock),
      .wr_block(st.taddr[BLK_LSB+BLK_W-1:BLK_LSB]),
      .rd_block(st.taddr[BLK_LSB+BLK_W-1:BLK_LSB]),
      .rd_protect(blk_prot),
      .rd_lock(blk_lock)
   );
   ////////////////////////////////////////////////////////////////////////////////
   // end-of-operation verdict
   always_comb
   begin
      fault = array_fail;
      // programming or erasing a locked block fails too
      if ((st.op == OP_PROG || st.op == OP_ERASE) && !blk_lock)
      begin
         fault = 1'b1; // [R11] [R12]
      end
      clr_protect = op_done && !fault && (st.op == OP_PROT); // [R3]
      clr_lock = op_done && !fault && (st.op == OP_LOCK);
   end
   ////////////////////////////////////////////////////////////////////////////////
   // sequencer, registers, serial handshake
   always_comb
   begin
      logic [1:0] ev; // events of this cycle
      ev = '0;
      next_st = st;
      if (st.accept_cnt != 2'd0)
      begin
         next_st.accept_cnt = st.accept_cnt - 2'd1;
      end
      // operation countdown and completion
      if (st.seq == SEQ_BUSY)
      begin
         next_st.timer = st.timer - TIMER_W'(1);
         if (op_done)
         begin
            next_st.seq = SEQ_IDLE; // [R4]
            ev[IRQ_DONE] = 1'b1;
            // return to the read mode of the erase-write mode
            next_st.rmode = st.ew1 ? RM_ARRAY : RM_STATUS; // [R18]
            if (fault)
            begin
               ev[IRQ_ERR] = 1'b1;
               if (st.op == OP_ERASE)
               begin
                  next_st.sr_erase = 1'b1; // [R11]
               end
               else
               begin
                  next_st.sr_prog = 1'b1; // [R12]
               end
            end
         end
      end
      // apb writes
      if (wr_acc)
      begin
         unique case (paddr)
            OFS_CMD:
            begin
               // commands are ignored while an operation runs
               if (st.seq != SEQ_BUSY)
               begin
                  unique case (wdat)
                     CMD_READ_ARRAY:
                     begin
                        next_st.seq = SEQ_IDLE;
                        next_st.rmode = RM_ARRAY; // [R19]
                     end
                     CMD_READ_STATUS:
                     begin
                        // not available in erase-write mode 1
                        if (!st.ew1)
                        begin
                           next_st.seq = SEQ_IDLE;
                           next_st.rmode = RM_STATUS; // [R19]
                        end
                     end
                     CMD_CLEAR:
                     begin
                        next_st.sr_erase = 1'b0; // [R17]
                        next_st.sr_prog = 1'b0; // [R17]
                     end
                     CMD_PROT_MODE:
                     begin
                        next_st.seq = SEQ_IDLE;
                        next_st.rmode = RM_PROT; // [R5]
                     end
                     CMD_PROGRAM, CMD_ERASE, CMD_LOCK, CMD_PROTECT:
                     begin
                        next_st.seq = SEQ_WAIT2; // [R1]
                        next_st.accept_cnt = 2'(ACCEPT_CYC);
                        next_st.op = (wdat == CMD_PROGRAM) ? OP_PROG :
                           (wdat == CMD_ERASE) ? OP_ERASE :
                           (wdat == CMD_LOCK) ? OP_LOCK : OP_PROT; // [R1]
                     end
                     default: ; // unknown command words change nothing
                  endcase
               end
            end
            OFS_TADDR:
            begin
               // the address stays fixed during an operation
               if (st.seq != SEQ_BUSY)
               begin
                  next_st.taddr = pwdata[ADDR_W-1:0];
               end
            end
            OFS_TDATA:
            begin
               // second write; dropped while the accept flag is still high
               if (st.seq == SEQ_WAIT2 && st.accept_cnt == 2'd0)
               begin
                  if (addr_bad)
                  begin
                     next_st.seq = SEQ_IDLE;
                     next_st.sr_erase = 1'b1; // [R10]
                     next_st.sr_prog = 1'b1; // [R10]
                     ev[IRQ_ERR] = 1'b1;
                  end
                  else if (st.op == OP_PROG || wdat == CMD_CONFIRM)
                  begin
                     next_st.seq = SEQ_BUSY; // [R1] [R4]
                     next_st.timer = TIMER_W'(OP_CYC);
                  end
                  else if (wdat == CMD_READ_ARRAY)
                  begin
                     next_st.seq = SEQ_IDLE; // cancelled
                     next_st.rmode = RM_ARRAY;
                  end
                  else
                  begin
                     next_st.seq = SEQ_IDLE;
                     next_st.sr_erase = 1'b1; // [R9]
                     next_st.sr_prog = 1'b1; // [R9]
                     ev[IRQ_ERR] = 1'b1;
                  end
               end
            end
            OFS_MODE0:
            begin
               next_st.ew1 = pwdata[MODE0_EW1];
               next_st.variant2 = pwdata[MODE0_VAR2];
               // erase-write mode 1 reads the array, or protect status after 0061h
               if (pwdata[MODE0_EW1])
               begin
                  next_st.rmode = RM_ARRAY;
               end
            end
            OFS_IRQ_ST: next_st.irq_st = st.irq_st & ~pwdata[1:0];
            OFS_IRQ_MASK: next_st.irq_mask = pwdata[1:0];
            default: ; // read-only and unmapped offsets ignore writes
         endcase
      end
      // a new event wins over a clear in the same cycle
      next_st.irq_st = next_st.irq_st | ev;
      // read data and error are captured in setup, shown in access
      if (setup)
      begin
         next_st.rdata = '0;
         next_st.slverr = 1'b0;
         unique case (paddr)
            OFS_CMD, OFS_TDATA: next_st.rdata = '0;
            OFS_TADDR: next_st.rdata = 32'(st.taddr);
            OFS_RDATA:
            begin
               unique case (st.rmode)
                  RM_ARRAY: next_st.rdata = 32'(array_rdata);
                  RM_STATUS: next_st.rdata = 32'(stat_word);
                  RM_PROT: next_st.rdata[PROT_STAT] = blk_prot; // [R6]
               endcase
            end
            OFS_MODE0:
            begin
               next_st.rdata[MODE0_ACCEPT] = (st.accept_cnt != 2'd0); // [R2]
               next_st.rdata[MODE0_EW1] = st.ew1;
               next_st.rdata[MODE0_VAR2] = st.variant2;
            end
            OFS_STAT0: next_st.rdata = 32'(stat_word); // [R8]
            OFS_IRQ_ST: next_st.rdata = 32'(st.irq_st);
            OFS_IRQ_MASK: next_st.rdata = 32'(st.irq_mask);
            default: next_st.slverr = 1'b1; // unmapped
         endcase
      end
      // serial clock edges count bits only in variant 1
      next_st.link_prev = sclk;
      if (st.hold != '0)
      begin
         next_st.hold = st.hold - TIMER_W'(1);
      end
      if (!serial_mode_active || st.variant2)
      begin
         next_st.bit_cnt = '0; // [R14]
      end
      else if (sclk && !st.link_prev)
      begin
         next_st.bit_cnt = st.bit_cnt + 3'd1;
         if (st.bit_cnt == 3'd7)
         begin
            next_st.hold = TIMER_W'(HOLD_CYC); // [R16]
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign prdata = st.rdata;
   assign pready = 1'b1; // zero wait states
   assign pslverr = st.slverr & psel & penable;
   assign irq = |(st.irq_st & st.irq_mask);
   assign serial_mode_active = boot_hi & ce_hi & ~epm_hi; // [R14]
   // variant 1 handshakes each byte; variant 2 only monitors the operation
   assign busy_pin = (st.seq == SEQ_BUSY) | (~st.variant2 & (st.hold != '0)); // [R16]
endmodule // fpsc_top

// ### verif/fpsc_flash_model.sv
// far side: array data, fault injection and serial programmer pins
`timescale 1ns/1ns
module fpsc_flash_model
(
   input wire logic pclk,
   input wire logic fail_req,
   input wire logic serial_on,
   input wire logic frame_go,
   output logic [15:0] array_rdata,
   output logic array_fail,
   output logic serial_clk_pin,
   output logic boot_select_pin,
   output logic ce_pin,
   output logic programming_mode_pin
);
   // data changes every cycle to expose stale reads
   initial array_rdata = 16'h5A5A;
   always @(posedge pclk) array_rdata <= array_rdata + 16'h31A7;
   assign array_fail = fail_req;
   // attached programmer sets the mode pins
   assign boot_select_pin = serial_on;
   assign ce_pin = serial_on;
   assign programming_mode_pin = !serial_on;
   // clock low through reset and idle between frames, 80 ns period in a frame
   initial serial_clk_pin = 1'b0;
   always @(posedge frame_go)
      repeat (8)
      begin
         #37 serial_clk_pin = 1'b1;
         #40 serial_clk_pin = 1'b0;
         #3;
      end
endmodule // fpsc_flash_model

// ### verif/fpsc_monitor.sv
// port-level checker for the flash protect and status slice
`timescale 1ns/1ns
module fpsc_monitor
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic busy_pin,
   input wire logic serial_mode_active,
   input wire logic boot_select_pin,
   input wire logic ce_pin,
   input wire logic programming_mode_pin
);
   import fpsc_pkg::*;
   logic acc; // access phase of any transfer
   logic rd_st; // status register read
   logic rd_rd; // flash data read
   logic [15:0] last_cmd; // last idle command, cleared by a data write
   assign acc = psel && penable;
   assign rd_st = acc && !pwrite && paddr == OFS_STAT0;
   assign rd_rd = acc && !pwrite && paddr == OFS_RDATA;
   ////////////////////////////////////////////////////////////////////////////////
   // command tracker; busy drops commands
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         last_cmd <= 16'h0000;
      else if (acc && pwrite && paddr == OFS_CMD && !busy_pin)
         last_cmd <= pwdata[15:0];
      else if (acc && pwrite && paddr == OFS_TDATA)
         last_cmd <= 16'h0000;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////////
   property p_op_busy;
      $rose(busy_pin) && !serial_mode_active |-> busy_pin [*8];
   endproperty
   a_op_busy: assert property (p_op_busy) else $error("busy dropped early");
   property p_rdy_lo;
      rd_st && $past(busy_pin) && !serial_mode_active |-> !prdata[STAT_READY];
   endproperty
   a_rdy_lo: assert property (p_rdy_lo) else $error("ready while busy");
   property p_rdy_hi;
      rd_st && !$past(busy_pin) && !serial_mode_active |-> prdata[STAT_READY];
   endproperty
   a_rdy_hi: assert property (p_rdy_hi) else $error("not ready when idle");
   property p_stat_rsv;
      rd_st |-> prdata[31:8] == 24'h00_0000 && !prdata[6] && prdata[3:0] == 4'h0;
   endproperty
   a_stat_rsv: assert property (p_stat_rsv) else $error("status reserved bits");
   property p_smode;
      $rose(serial_mode_active) |-> boot_select_pin && ce_pin && !programming_mode_pin;
   endproperty
   a_smode: assert property (p_smode) else $error("serial mode pins");
   property p_hshake;
      $rose(busy_pin) && serial_mode_active |-> ##1 busy_pin [*8];
   endproperty
   a_hshake: assert property (p_hshake) else $error("handshake too short");
   property p_clr;
      rd_st && last_cmd == CMD_CLEAR |-> prdata[5:4] == 2'b00;
   endproperty
   a_clr: assert property (p_clr) else $error("faults not cleared");
   property p_prot;
      rd_rd && last_cmd == CMD_PROT_MODE |-> (prdata & 32'hFFFF_FFBF) == 32'h0000_0000;
   endproperty
   a_prot: assert property (p_prot) else $error("protect status word");
   c_busy: cover property (rd_st && !prdata[STAT_READY]);
   c_prot: cover property (rd_rd && last_cmd == CMD_PROT_MODE);
   c_ser: cover property ($rose(serial_mode_active));
endmodule // fpsc_monitor

// ### verif/tb.sv
// self-checking bench for the flash protect and status slice
`timescale 1ns/1ns
module tb;
   import fpsc_pkg::*;
   logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, busy_pin, serial_mode_active, irq, slv;
   logic [15:0] array_rdata;
   logic array_fail, serial_clk_pin, boot_select_pin, ce_pin, programming_mode_pin;
   logic fail_req = 1'b0, serial_on = 1'b0, frame_go = 1'b0;
   int num_errors = 0, n_compared = 0;
   fpsc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .array_rdata, .array_fail, .serial_clk_pin, .boot_select_pin,
      .ce_pin, .programming_mode_pin, .busy_pin, .serial_mode_active, .irq);
   fpsc_flash_model far_u (.pclk, .fail_req, .serial_on, .frame_go, .array_rdata,
      .array_fail, .serial_clk_pin, .boot_select_pin, .ce_pin, .programming_mode_pin);
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // a hang counts as a mismatch
   initial
   begin
      #100000;
      num_errors++;
      test_done();
   end
   ////////////////////////////////////////////////////////////////////////////////
   // one apb transfer, request held until pready is seen
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      slv = pslverr;
      {psel, penable} <= 2'b00;
      @(posedge pclk);
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e)
      begin
         num_errors++;
         $display("ERROR %0t: got %h expected %h", $time, s, e);
      end
   endtask
   // two-write command, poll ready, check and clear the outcome
   task automatic op(input logic [15:0] c, input logic [19:0] ta, input logic [15:0] d,
      input logic rdy, input logic [31:0] e);
      logic [31:0] r;
      xfer(1'b1, OFS_TADDR, {12'h000, ta}, r);
      xfer(1'b1, OFS_CMD, {16'h0000, c}, r);
      r = 32'h0000_0001;
      while (r[MODE0_ACCEPT] !== 1'b0) xfer(1'b0, OFS_MODE0, 32'h0, r);
      xfer(1'b1, OFS_TDATA, {16'h0000, d}, r);
      xfer(1'b0, OFS_STAT0, 32'h0, r);
      chk({31'h0, r[STAT_READY]}, {31'h0, rdy});
      while (r[STAT_READY] !== 1'b1) xfer(1'b0, OFS_STAT0, 32'h0, r);
      chk(r, e);
      if (rdy === 1'b0)
      begin
         xfer(1'b0, OFS_RDATA, 32'h0, r);
         chk(r, e);
      end
      xfer(1'b1, OFS_CMD, {16'h0000, CMD_CLEAR}, r);
      xfer(1'b0, OFS_STAT0, 32'h0, r);
      chk(r, 32'h0000_0080);
   endtask
   task test_done;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      xfer(1'b0, 8'h20, 32'h0, q);
      chk({31'h0, slv}, 32'h1);
      xfer(1'b1, OFS_IRQ_MASK, 32'h0000_0003, q);
      op(CMD_PROTECT, 20'h2_0000, CMD_CONFIRM, 1'b0, 32'h0000_0080);
      chk({31'h0, irq}, 32'h1);
      xfer(1'b1, OFS_IRQ_ST, 32'h0000_0003, q);
      chk({31'h0, irq}, 32'h0);
      xfer(1'b1, OFS_CMD, {16'h0000, CMD_PROT_MODE}, q);
      xfer(1'b0, OFS_RDATA, 32'h0, q);
      chk(q, 32'h0000_0000);
      xfer(1'b1, OFS_TADDR, 32'h0003_0000, q);
      xfer(1'b0, OFS_RDATA, 32'h0, q);
      chk(q, 32'h0000_0040);
      xfer(1'b1, OFS_IRQ_MASK, 32'h0000_0001, q);
      op(CMD_PROTECT, 20'h3_0000, 16'h1234, 1'b1, 32'h0000_00B0);
      chk({31'h0, irq}, 32'h0);
      xfer(1'b1, OFS_IRQ_MASK, 32'h0000_0003, q);
      chk({31'h0, irq}, 32'h1);
      op(CMD_LOCK, 20'h8_0000, CMD_CONFIRM, 1'b1, 32'h0000_00B0);
      op(CMD_ERASE, 20'h1_0000, CMD_READ_ARRAY, 1'b1, 32'h0000_0080);
      op(CMD_LOCK, 20'h1_0000, CMD_CONFIRM, 1'b0, 32'h0000_0080);
      op(CMD_ERASE, 20'h1_0000, CMD_CONFIRM, 1'b0, 32'h0000_00A0);
      op(CMD_PROGRAM, 20'h1_0004, 16'h0042, 1'b0, 32'h0000_0090);
      fail_req <= 1'b1;
      op(CMD_PROTECT, 20'h5_0000, CMD_CONFIRM, 1'b0, 32'h0000_0090);
      fail_req <= 1'b0;
      serial_on <= 1'b1;
      repeat (8) @(posedge pclk);
      chk({31'h0, serial_mode_active}, 32'h1);
      frame_go <= 1'b1;
      for (int i = 0; i < 400 && busy_pin !== 1'b1; i++) @(posedge pclk);
      chk({31'h0, busy_pin}, 32'h1);
      frame_go <= 1'b0;
      repeat (HOLD_CYC + 200) @(posedge pclk);
      xfer(1'b1, OFS_MODE0, 32'h0000_0004, q);
      frame_go <= 1'b1;
      q = '0;
      repeat (250) @(posedge pclk) q[0] = q[0] | busy_pin;
      chk(q, 32'h0);
      test_done();
   end
endmodule // tb
bind fpsc_top fpsc_monitor mon_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .busy_pin, .serial_mode_active, .boot_select_pin, .ce_pin,
   .programming_mode_pin);
